// ==== addon_master.sv ====
// passive add-on local bus master: window and register accesses, done, address strobe
// assumes core_clk from the bench; drives after the falling edge, samples after the rising edge
`timescale 1ns/1ps
module addon_master (
    // clock
    input  wire logic        core_clk,
    // local bus requests
    output logic             rd_n,
    output logic             wr_n,
    output logic             select_n,
    output logic [4:0]       adr,
    output logic [3:0]       local_byte_select_n,
    output logic [31:0]      dq_in,
    output logic             address_out_strobe_n,
    output logic             transfer_done_n,
    // answers
    input  wire logic [31:0] dq_out,
    input  wire logic        dq_oe
);
    initial begin
        rd_n = 1'b1;
        wr_n = 1'b1;
        select_n = 1'b1;
        adr = 5'h00;
        local_byte_select_n = 4'hF;
        dq_in = 32'h0000_0000;
        address_out_strobe_n = 1'b1;
        transfer_done_n = 1'b1;
    end

    // narrow buses move one byte or word per call, the caller picks the selects
    task automatic access(input logic is_wr, input logic [4:0] a, input logic [3:0] sel,
                          input logic [31:0] d, output logic [31:0] q, output logic oe);
        @(negedge core_clk);
        rd_n = is_wr;
        wr_n = ~is_wr;
        select_n = 1'b0;
        adr = a;
        local_byte_select_n = sel;
        dq_in = is_wr ? d : ~dq_in;
        @(posedge core_clk);
        #1;
        q = dq_out;
        oe = dq_oe;
        @(negedge core_clk);
        rd_n = 1'b1;
        wr_n = 1'b1;
        select_n = 1'b1;
        local_byte_select_n = 4'hF;
        // released lanes must not keep looking like valid data
        dq_in = ~dq_in;
    endtask : access

    // only called once the bench has seen every pending flag drop
    task automatic done;
        @(negedge core_clk);
        transfer_done_n = 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        transfer_done_n = 1'b1;
    endtask : done

    task automatic strobe(output logic [31:0] q, output logic oe);
        @(negedge core_clk);
        address_out_strobe_n = 1'b0;
        // held across a rising edge, where the add-on latches the address
        @(posedge core_clk);
        #1;
        q = dq_out;
        oe = dq_oe;
        @(negedge core_clk);
        address_out_strobe_n = 1'b1;
    endtask : strobe
endmodule : addon_master

// ==== lane_steer.sv ====
// byte lane steering for data window reads and writes
// assumes width holds one of the passthru_pkg width codes
`timescale 1ns/1ps
module lane_steer (
    lane_steer_if.steer sif
);
    // read: lanes at or below the lowest selected byte repeat that byte
    always_comb begin
        logic       found;
        logic [7:0] rep;
        found = 1'b0;
        rep   = sif.window[7:0];
        sif.rd_lanes = sif.window;
        for (int n = passthru_pkg::LANES - 1; n >= 0; n--) begin
            if (!sif.select_n[n]) begin
                rep = sif.window[n*8 +: 8];
            end
        end
        for (int n = 0; n < passthru_pkg::LANES; n++) begin
            if (!found) begin
                sif.rd_lanes[n*8 +: 8] = rep;
            end
            if (!sif.select_n[n]) begin
                found = 1'b1;
            end
        end
    end

    // write: narrow regions fold the low lanes onto all bytes
    always_comb begin
        case (sif.width)
            passthru_pkg::WIDTH_16: sif.wr_bytes = {2{sif.dq_in[15:0]}};
            passthru_pkg::WIDTH_8:  sif.wr_bytes = {4{sif.dq_in[7:0]}};
            default:                sif.wr_bytes = sif.dq_in;
        endcase
    end
endmodule : lane_steer

// ==== lane_steer_if.sv ====
// carries the data window and local lanes between the bridge and its steering logic
// assumes one clock domain; all signals are combinational
`timescale 1ns/1ps
interface lane_steer_if;
    logic [31:0] window;
    logic [3:0]  select_n;
    logic [1:0]  width;
    logic [31:0] dq_in;
    logic [31:0] rd_lanes;
    logic [31:0] wr_bytes;
    modport bridge (output window, select_n, width, dq_in, input rd_lanes, wr_bytes);
    modport steer  (input window, select_n, width, dq_in, output rd_lanes, wr_bytes);
endinterface : lane_steer_if

// ==== passthru_narrow_bridge.sv ====
// passive add-on side of the pass-through data path for 8/16/32-bit buses
// assumes the pci side presents each access with its dword count and byte enables,
// and that the add-on master keeps its own handshake duties
// Notes on behaviour
// - each region has own width 8/16/32
// - steering only on the data window
// - read repeats lowest selected byte downward
// - reading byte n clears its pending flag
// - pending flags show bytes pci requested
// - write lanes routed by region width
// - write byte only if pending and selected
// - written byte clears its pending flag
// - address strobe drives address asynchronously
// - address register readable one cycle later
// - 16-bit strap halves address by select 3
// - region width ignored for address reads
// - status outputs update next edge
// - status valid only while access pending
// - burst, region, direction meanings
// - selected byte driven next cycle
// - done reloads pending flags for next dword
// - burst drops when one dword remains
// - pending drops after final phase
`timescale 1ns/1ps
module passthru_narrow_bridge #(
    parameter int unsigned CNT_W = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    // configuration
    input  wire logic [7:0]       region_width,
    input  wire logic             local_width_strap,
    // pci side access feed
    input  wire logic             acc_start,
    input  wire logic [31:0]      acc_address,
    input  wire logic [1:0]       acc_region,
    input  wire logic             acc_write,
    input  wire logic [CNT_W-1:0] acc_count,
    input  wire logic [31:0]      cur_data,
    input  wire logic [3:0]       cur_be_n,
    input  wire logic [31:0]      nxt_data,
    input  wire logic [3:0]       nxt_be_n,
    output logic                  phase_advance,
    output logic [31:0]           filled_data,
    output logic                  filled_valid,
    // add-on local bus
    input  wire logic             rd_n,
    input  wire logic             wr_n,
    input  wire logic             select_n,
    input  wire logic [4:0]       adr,
    input  wire logic [3:0]       local_byte_select_n,
    input  wire logic [31:0]      dq_in,
    output logic [31:0]           dq_out,
    output logic                  dq_oe,
    input  wire logic             address_out_strobe_n,
    input  wire logic             transfer_done_n,
    // pass-through status
    output logic                  access_pending_n,
    output logic                  multi_phase_n,
    output logic [1:0]            region_index,
    output logic                  access_is_write,
    output logic [3:0]            byte_pending_n
);
    passthru_pkg::phase_e state;
    logic [31:0]      addr_cap;
    logic [31:0]      window;
    logic [CNT_W-1:0] remaining;
    logic [31:0]      rd_word;
    logic             rd_drive;
    logic             data_hit;
    logic             addr_hit;
    logic             rd_data;
    logic             wr_data;
    logic             rd_addr;
    logic             done;
    logic             last_phase;
    logic             start;
    logic [31:0]      addr_word;
    logic [CNT_W-1:0] one;
    logic [CNT_W-1:0] two;

    lane_steer_if sif ();

    lane_steer i_lane_steer (
        .sif (sif)
    );

    assign one = CNT_W'(1);
    assign two = CNT_W'(2);

    // only the data window is steered; the address capture offset reads back addr_word
    assign data_hit = !select_n && (adr == passthru_pkg::DATA_WINDOW_IDX);
    assign addr_hit = !select_n && (adr == passthru_pkg::ADDR_CAPTURE_IDX);
    assign rd_data  = data_hit && !rd_n;
    assign wr_data  = data_hit && !wr_n;
    assign rd_addr  = addr_hit && !rd_n;
    assign done     = (state == passthru_pkg::ST_BUSY) && !transfer_done_n;
    assign last_phase = (remaining <= one);
    assign start    = (state == passthru_pkg::ST_IDLE) && acc_start;

    // width is per region, picked by the pending region number
    assign sif.window   = window;
    assign sif.select_n = local_byte_select_n;
    assign sif.width    = region_width[region_index*2 +: 2];
    assign sif.dq_in    = dq_in;

    // strap low means a 16-bit add-on bus; region width plays no part here
    always_comb begin
        if (local_width_strap) begin
            addr_word = addr_cap;
        end else if (local_byte_select_n[3]) begin
            addr_word = {passthru_pkg::HALF_ZERO, addr_cap[31:16]};
        end else begin
            addr_word = {passthru_pkg::HALF_ZERO, addr_cap[15:0]};
        end
    end

    // access sequencing
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= passthru_pkg::ST_IDLE;
        end else begin
            case (state)
                passthru_pkg::ST_IDLE: begin
                    if (acc_start) begin
                        state <= passthru_pkg::ST_BUSY;
                    end
                end
                passthru_pkg::ST_BUSY: begin
                    if (done && last_phase) begin
                        state <= passthru_pkg::ST_IDLE;
                    end
                end
                default: state <= passthru_pkg::ST_IDLE;
            endcase
        end
    end

    // status outputs, valid while access_pending_n is low
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            access_pending_n <= 1'b1;
            multi_phase_n    <= 1'b1;
            region_index     <= 2'h0;
            access_is_write  <= 1'b0;
            remaining        <= '0;
            addr_cap         <= passthru_pkg::WORD_ZERO;
        end else if (start) begin
            access_pending_n <= 1'b0;
            multi_phase_n    <= !(acc_count >= two);
            region_index     <= acc_region;
            access_is_write  <= acc_write;
            remaining        <= acc_count;
            addr_cap         <= acc_address;
        end else if (done) begin
            if (last_phase) begin
                access_pending_n <= 1'b1;
                multi_phase_n    <= 1'b1;
            end else begin
                remaining     <= remaining - one;
                multi_phase_n <= (remaining <= two);
            end
        end
    end

    // byte pending flags
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            byte_pending_n <= passthru_pkg::NONE_N;
        end else if (start) begin
            byte_pending_n <= cur_be_n;
        end else if (done) begin
            byte_pending_n <= last_phase ? passthru_pkg::NONE_N : nxt_be_n;
        end else if (rd_data && access_is_write) begin
            byte_pending_n <= byte_pending_n | ~local_byte_select_n;
        end else if (wr_data && !access_is_write) begin
            byte_pending_n <= byte_pending_n | ~local_byte_select_n;
        end
    end

    // data window: pci write data loads here, add-on writes fill bytes for pci reads
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            window <= passthru_pkg::WORD_ZERO;
        end else if (start) begin
            window <= cur_data;
        end else if (done) begin
            window <= nxt_data;
        end else if (wr_data && !access_is_write) begin
            for (int n = 0; n < passthru_pkg::LANES; n++) begin
                if (!byte_pending_n[n] && !local_byte_select_n[n]) begin
                    window[n*8 +: 8] <= sif.wr_bytes[n*8 +: 8];
                end
            end
        end
    end

    // hand the filled dword to the pci side when a read phase completes
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_advance <= 1'b0;
            filled_valid  <= 1'b0;
            filled_data   <= passthru_pkg::WORD_ZERO;
        end else begin
            phase_advance <= done;
            filled_valid  <= done && !access_is_write;
            if (done && !access_is_write) begin
                filled_data <= window;
            end
        end
    end

    // register read data, presented the cycle after the sampled request
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_word  <= passthru_pkg::WORD_ZERO;
            rd_drive <= 1'b0;
        end else begin
            rd_drive <= rd_data || rd_addr;
            if (rd_data) begin
                rd_word <= sif.rd_lanes;
            end else if (rd_addr) begin
                rd_word <= addr_word;
            end
        end
    end

    // the strobe path is deliberately combinational so the address appears with no clock
    assign dq_out = !address_out_strobe_n ? addr_cap : rd_word;
    assign dq_oe  = !address_out_strobe_n || rd_drive;

    // checks

    AST_READ_CLEARS_PENDING: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (rd_data && access_is_write && !start && !done && !local_byte_select_n[0])
        |=> byte_pending_n[0])
        else $error("read of byte 0 left its pending flag set");

    AST_WRITE_CLEARS_PENDING: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (wr_data && !access_is_write && !start && !done && !local_byte_select_n[1])
        |=> byte_pending_n[1])
        else $error("write of byte 1 left its pending flag set");

    AST_WRITE_NEEDS_PENDING: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (wr_data && byte_pending_n[2] && !start && !done)
        |=> (window[23:16] == $past(window[23:16])))
        else $error("byte 2 written while not pending");

    AST_STATUS_NEXT_EDGE: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        start |=> (!access_pending_n && region_index == $past(acc_region)
                   && access_is_write == $past(acc_write)))
        else $error("status outputs not updated after access start");

    AST_BURST_DROPS: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (done && remaining == two) |=> (multi_phase_n && !access_pending_n))
        else $error("burst still asserted with one dword left");

    AST_PENDING_ENDS: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (done && last_phase) |=> (access_pending_n && multi_phase_n && byte_pending_n == passthru_pkg::NONE_N))
        else $error("access still pending after final phase");

    AST_STROBE_ADDRESS: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !address_out_strobe_n |-> (dq_oe && dq_out == addr_cap))
        else $error("address not on data bus while strobe asserted");

    AST_ADDR_REG_READ: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (rd_addr && local_width_strap && !start) ##1 address_out_strobe_n
        |-> (dq_oe && dq_out == addr_cap))
        else $error("address register read data missing");

    AST_BYTE_NEXT_CYCLE: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (rd_data && !local_byte_select_n[0] && !start && !done) ##1 address_out_strobe_n
        |-> (dq_oe && dq_out[7:0] == window[7:0]))
        else $error("selected byte not driven in the following cycle");

    AST_NO_SELECT_STABLE: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (data_hit && local_byte_select_n == passthru_pkg::NONE_N && !start && !done)
        |=> ($stable(byte_pending_n) && $stable(window)))
        else $error("access without byte select changed state");

    AST_PENDING_LOADS: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        start |=> (byte_pending_n == $past(cur_be_n)))
        else $error("pending flags not loaded from the first dword");

    AST_DONE_RELOADS: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (done && !last_phase) |=> (byte_pending_n == $past(nxt_be_n) && phase_advance))
        else $error("pending flags not reloaded for the next dword");

    AST_STATUS_HOLDS: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (!access_pending_n && !done)
        |=> (!access_pending_n && $stable(region_index) && $stable(access_is_write)))
        else $error("status changed while the access was pending");

    AST_READ_STEERS_LOW: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (rd_data && local_byte_select_n[1:0] == 2'h1) ##1 address_out_strobe_n
        |-> (dq_out[15:0] == {2{$past(window[15:8])}}))
        else $error("lanes 0 and 1 do not carry byte 1");

    AST_ADDR_LOW_HALF: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (rd_addr && !local_width_strap && !local_byte_select_n[3] && !start) ##1 address_out_strobe_n
        |-> (dq_out[15:0] == addr_cap[15:0]))
        else $error("address low half missing on a 16-bit strap read");

    AST_ADDR_HIGH_HALF: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (rd_addr && !local_width_strap && local_byte_select_n[3] && !start) ##1 address_out_strobe_n
        |-> (dq_out[15:0] == addr_cap[31:16]))
        else $error("address high half missing on a 16-bit strap read");

    AST_HALF_WIDTH_WRITE: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (wr_data && !access_is_write && sif.width == passthru_pkg::WIDTH_16 && !byte_pending_n[3]
         && !local_byte_select_n[3] && !start && !done)
        |=> (window[31:24] == $past(dq_in[15:8])))
        else $error("16-bit write did not steer the high lane into byte 3");

    COV_BURST_ACCESS: cover property (
        @(posedge core_clk) disable iff (!rst_b)
        start ##1 !multi_phase_n ##[1:40] (done && last_phase));

    COV_NARROW_WRITE: cover property (
        @(posedge core_clk) disable iff (!rst_b)
        (wr_data && !access_is_write && sif.width == passthru_pkg::WIDTH_8));

    COV_STROBE_READ: cover property (
        @(posedge core_clk) disable iff (!rst_b)
        (!access_pending_n && !address_out_strobe_n));

    COV_HALF_ADDR: cover property (
        @(posedge core_clk) disable iff (!rst_b)
        (rd_addr && !local_width_strap && local_byte_select_n[3]));
endmodule : passthru_narrow_bridge

// ==== passthru_narrow_bus_byte_steering_tb.sv ====
// self-checking bench: pci side fed directly, add-on side through the master model
// assumes default CNT_W; every expectation comes from the steering rules
`timescale 1ns/1ps
module passthru_narrow_bus_byte_steering_tb;
    localparam logic [31:0] ADDR = 32'hC0DE_0104;
    localparam logic [31:0] W0   = 32'h08D4_9A30;
    localparam logic [31:0] W1   = 32'hAABB_CCDD;
    logic        core_clk, rst_b, local_width_strap, acc_start, acc_write, phase_advance;
    logic        filled_valid, rd_n, wr_n, select_n, address_out_strobe_n, transfer_done_n;
    logic        dq_oe, access_pending_n, multi_phase_n, access_is_write, oe;
    logic [7:0]  region_width, acc_count;
    logic [1:0]  acc_region, region_index;
    logic [31:0] acc_address, cur_data, nxt_data, filled_data, dq_in, dq_out, q;
    logic [3:0]  cur_be_n, nxt_be_n, local_byte_select_n, byte_pending_n, seen;
    logic [4:0]  adr;
    int          bad_count, checks;

    passthru_narrow_bridge #(.CNT_W(8)) i_passthru_narrow_bridge (.core_clk(core_clk), .rst_b(rst_b),
        .region_width(region_width), .local_width_strap(local_width_strap), .acc_start(acc_start),
        .acc_address(acc_address), .acc_region(acc_region), .acc_write(acc_write), .acc_count(acc_count),
        .cur_data(cur_data), .cur_be_n(cur_be_n), .nxt_data(nxt_data), .nxt_be_n(nxt_be_n),
        .phase_advance(phase_advance), .filled_data(filled_data), .filled_valid(filled_valid),
        .rd_n(rd_n), .wr_n(wr_n), .select_n(select_n), .adr(adr), .local_byte_select_n(local_byte_select_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .address_out_strobe_n(address_out_strobe_n),
        .transfer_done_n(transfer_done_n), .access_pending_n(access_pending_n), .multi_phase_n(multi_phase_n),
        .region_index(region_index), .access_is_write(access_is_write), .byte_pending_n(byte_pending_n));

    addon_master i_addon_master (.core_clk(core_clk), .rd_n(rd_n), .wr_n(wr_n), .select_n(select_n),
        .adr(adr), .local_byte_select_n(local_byte_select_n), .dq_in(dq_in),
        .address_out_strobe_n(address_out_strobe_n), .transfer_done_n(transfer_done_n),
        .dq_out(dq_out), .dq_oe(dq_oe));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // lanes at or below the lowest selected byte repeat that byte
    function automatic logic [31:0] steer_rd(input logic [31:0] w, input logic [3:0] sel);
        logic [31:0] r;
        int          n;
        r = w;
        n = 0;
        while (n < 3 && sel[n]) n++;
        for (int k = 0; k < n; k++) r[8*k +: 8] = w[8*n +: 8];
        return r;
    endfunction : steer_rd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic stat(input logic [8:0] e);
        chk({23'h0, access_pending_n, multi_phase_n, region_index, access_is_write, byte_pending_n}, {23'h0, e});
    endtask : stat

    task automatic start(input logic [1:0] r, input logic w, input logic [7:0] n, input logic [3:0] b0,
                         input logic [31:0] d1, input logic [3:0] b1);
        @(negedge core_clk);
        acc_start = 1'b1;
        acc_region = r;
        acc_write = w;
        acc_count = n;
        cur_data = W0;
        cur_be_n = b0;
        nxt_data = d1;
        nxt_be_n = b1;
        @(negedge core_clk);
        acc_start = 1'b0;
    endtask : start

    task automatic wr(input logic [3:0] sel, input logic [31:0] d, input logic [3:0] pend);
        i_addon_master.access(1'b1, passthru_pkg::DATA_WINDOW_IDX, sel, d, q, oe);
        chk({28'h0, byte_pending_n}, {28'h0, pend});
    endtask : wr

    // filled_valid is a short pulse, so poll for it under a bound
    task automatic fill_chk(input logic [31:0] mask, input logic [31:0] exp);
        int i;
        i = 0;
        while (filled_valid !== 1'b1 && i < 4) begin
            @(negedge core_clk);
            i++;
        end
        chk({31'h0, filled_valid}, 32'h1);
        chk(filled_data & mask, exp);
    endtask : fill_chk

    task automatic tally_and_finish;
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #(3000 * 20);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        bad_count = 0;
        checks = 0;
        rst_b = 1'b0;
        region_width = {passthru_pkg::WIDTH_8, passthru_pkg::WIDTH_32, passthru_pkg::WIDTH_16,
                        passthru_pkg::WIDTH_8};
        local_width_strap = 1'b1;
        acc_start = 1'b0;
        acc_address = ADDR;
        acc_region = 2'h0;
        acc_write = 1'b0;
        acc_count = 8'h01;
        cur_data = passthru_pkg::WORD_ZERO;
        cur_be_n = passthru_pkg::NONE_N;
        nxt_data = passthru_pkg::WORD_ZERO;
        nxt_be_n = passthru_pkg::NONE_N;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        rst_b = 1'b1;
        // pci write of two dwords into the 8-bit region 0
        start(2'h0, 1'b1, 8'h02, 4'h0, W1, 4'h8);
        stat({1'b0, 1'b0, 2'h0, 1'b1, 4'h0});
        i_addon_master.strobe(q, oe);
        chk(q, ADDR);
        chk({31'h0, oe}, 32'h1);
        i_addon_master.access(1'b0, passthru_pkg::DATA_WINDOW_IDX, passthru_pkg::NONE_N, W1, q, oe);
        chk({28'h0, byte_pending_n}, 32'h0);
        seen = 4'h0;
        for (int n = 0; n < 4; n++) begin
            i_addon_master.access(1'b0, passthru_pkg::DATA_WINDOW_IDX, ~(4'h1 << n), W1, q, oe);
            seen = seen | (4'h1 << n);
            chk(q, steer_rd(W0, ~(4'h1 << n)));
            chk({31'h0, oe}, 32'h1);
            chk({28'h0, byte_pending_n}, {28'h0, seen});
        end
        i_addon_master.done();
        stat({1'b0, 1'b1, 2'h0, 1'b1, 4'h8});
        chk({31'h0, phase_advance}, 32'h1);
        i_addon_master.access(1'b0, passthru_pkg::DATA_WINDOW_IDX, 4'hB, W0, q, oe);
        chk(q, steer_rd(W1, 4'hB));
        i_addon_master.access(1'b0, passthru_pkg::DATA_WINDOW_IDX, 4'hE, W0, q, oe);
        chk(q, W1);
        i_addon_master.access(1'b0, passthru_pkg::DATA_WINDOW_IDX, 4'hD, W0, q, oe);
        chk(q, steer_rd(W1, 4'hD));
        chk({28'h0, byte_pending_n}, 32'hF);
        i_addon_master.done();
        chk({26'h0, access_pending_n, multi_phase_n, byte_pending_n}, 32'h3F);
        // address register through the bus, both strap settings
        i_addon_master.access(1'b0, passthru_pkg::ADDR_CAPTURE_IDX, 4'h0, W0, q, oe);
        chk(q, ADDR);
        local_width_strap = 1'b0;
        i_addon_master.access(1'b0, passthru_pkg::ADDR_CAPTURE_IDX, 4'h0, W0, q, oe);
        chk({16'h0, q[15:0]}, {16'h0, ADDR[15:0]});
        i_addon_master.access(1'b0, passthru_pkg::ADDR_CAPTURE_IDX, 4'h8, W0, q, oe);
        chk({16'h0, q[15:0]}, {16'h0, ADDR[31:16]});
        // pci reads: 16-bit region 1, 8-bit region 3, 32-bit region 2
        start(2'h1, 1'b0, 8'h01, 4'h0, W1, 4'hF);
        stat({1'b0, 1'b1, 2'h1, 1'b0, 4'h0});
        wr(4'hC, 32'h5555_3344, 4'h3);
        wr(4'h3, 32'h6666_1122, 4'hF);
        wr(4'hE, 32'h0000_0099, 4'hF);
        i_addon_master.done();
        fill_chk(32'hFFFF_FFFF, 32'h1122_3344);
        start(2'h3, 1'b0, 8'h01, 4'hB, W1, 4'hF);
        wr(4'h0, 32'h0000_005A, 4'hF);
        i_addon_master.done();
        fill_chk(32'h00FF_0000, 32'h005A_0000);
        start(2'h2, 1'b0, 8'h01, 4'h0, W1, 4'hF);
        wr(4'h0, 32'hDEAD_BEEF, 4'hF);
        i_addon_master.done();
        fill_chk(32'hFFFF_FFFF, 32'hDEAD_BEEF);
        tally_and_finish();
    end
endmodule : passthru_narrow_bus_byte_steering_tb

// ==== passthru_pkg.sv ====
// constants shared by the narrow-bus pass-through bridge
// assumes the add-on address bus carries byte address bits 6:2
package passthru_pkg;
    localparam logic [7:0] ADDR_CAPTURE_OFS = 8'h28;
    localparam logic [7:0] DATA_WINDOW_OFS  = 8'h2C;
    localparam logic [4:0] ADDR_CAPTURE_IDX = ADDR_CAPTURE_OFS[6:2];
    localparam logic [4:0] DATA_WINDOW_IDX  = DATA_WINDOW_OFS[6:2];
    // two-bit per-region width code
    localparam logic [1:0] WIDTH_8  = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;
    localparam int unsigned REGIONS   = 4;
    localparam int unsigned LANES     = 4;
    localparam logic [3:0]  NONE_N    = 4'hF;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [15:0] HALF_ZERO = 16'h0000;
    typedef enum logic {ST_IDLE, ST_BUSY} phase_e;
endpackage : passthru_pkg
